// ### core/ocs_clock_select.sv
// Clock mode selection, oscillator watchdog and backup clock switch.
// How it works
// R1: Mode pins sampled during reset select clock mode, held until next reset.
// R2: Watchdog supervision exists only in direct and prescaled direct modes.
// R3: Watchdog is enabled after reset without software action.
// R4: Writing one to configuration bit 4 disables the watchdog.
// R5: Enabled watchdog runs PLL free-running; each PLL clock increments counter.
// R6: Every external clock transition clears the watchdog counter.
// R7: Sixteen PLL clocks without a transition overflow the counter, meaning failure.
// R8: Overflow moves CPU clock to PLL free-running clock and flags interrupt.
// R9: Backup clock stays selected even when external clock returns.
// R10: Only a reset returns the CPU clock to the external input.
// R11: Disabled watchdog uses external clock only and powers the PLL off; disabled after a swap, backup clock stays selected with the PLL off.
// R12: Other mode codes enable the PLL and multiply the crystal frequency.
// R13: In PLL modes the PLL resynchronises smoothly every F input transitions.
// R14: Codes 111,110,101,100 use divide 4, multiply 64,48,64,40, divide 4,4,2,2.
// R15: Code 010 is /2, x40, /2; code 000 is /2, x64, /2.
// R16: Code 011 bypasses the PLL; code 001 bypasses and halves in prescaler while the external clock is selected.
// R17: Integrator keeps PLL input, VCO and CPU clock within their ranges.
// R18: Switch to the backup clock is glitch-free.
`timescale 1ns/10ps
module ocs_clock_select (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [2:0] clock_mode_pins,
  input  wire logic       crystal_input_pin,
  input  wire logic       pll_free_clk,
  input  wire logic       cfg_write,
  input  wire logic [7:0] system_config_register,
  output logic [2:0]      clock_mode,
  output logic            pll_enable,
  output logic            pll_free_run,
  output logic [2:0]      in_prescale,
  output logic [6:0]      vco_multiply,
  output logic [2:0]      pll_divide,
  output logic            out_prescale_half,
  output logic [4:0]      clock_factor,
  output logic            resync_pulse,
  output logic            owd_enabled,
  output logic            owd_irq_flag,
  output logic            sel_ext_clk,
  output logic            sel_backup_clk
);

  // ----------------------------------------
  // Input synchronisers.
  // ----------------------------------------
  logic xtal_s;
  logic xtal_chg;
  logic pll_s;
  logic pll_chg;

  ocs_sync u_xtal_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (crystal_input_pin),
    .dout    (xtal_s),
    .changed (xtal_chg)
  );

  ocs_sync u_pll_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (pll_free_clk),
    .dout    (pll_s),
    .changed (pll_chg)
  );

  logic pll_rise;
  assign pll_rise = pll_chg & pll_s;

  // ----------------------------------------
  // Mode capture and PLL settings.
  // ----------------------------------------
  logic [2:0] mode_q;
  logic [2:0] mode_d;
  logic       direct_mode;
  logic [2:0] in_pre_c;
  logic [6:0] vco_c;
  logic [2:0] div_c;
  logic [4:0] fac_c;

  always_comb begin
    mode_d = rst ? clock_mode_pins : mode_q; // see R1
  end

  always_ff @(posedge clk_sys) begin
    mode_q <= mode_d;
  end

  assign direct_mode = (mode_q == ocs_pkg::MODE_DIRECT) || (mode_q == ocs_pkg::MODE_PRESCALE); // see R2

  always_comb begin
    in_pre_c = ocs_pkg::IN_DIV_1;
    vco_c    = ocs_pkg::VCO_MUL_0;
    div_c    = ocs_pkg::PLL_DIV_1;
    fac_c    = ocs_pkg::FACTOR_1;
    case (mode_q)
      ocs_pkg::MODE_X4: begin
        in_pre_c = ocs_pkg::IN_DIV_4; vco_c = ocs_pkg::VCO_MUL_64; // see R14
      end
      default: ;
    endcase
    case (mode_q)
      ocs_pkg::MODE_X4: begin
        div_c = ocs_pkg::PLL_DIV_4;
        fac_c = ocs_pkg::FACTOR_4;
      end
      ocs_pkg::MODE_X3: begin
        in_pre_c = ocs_pkg::IN_DIV_4;
        vco_c    = ocs_pkg::VCO_MUL_48;
        div_c    = ocs_pkg::PLL_DIV_4;
        fac_c    = ocs_pkg::FACTOR_3; // see R14
      end
      ocs_pkg::MODE_X8: begin
        in_pre_c = ocs_pkg::IN_DIV_4;
        vco_c    = ocs_pkg::VCO_MUL_64;
        div_c    = ocs_pkg::PLL_DIV_2;
        fac_c    = ocs_pkg::FACTOR_8; // see R14
      end
      ocs_pkg::MODE_X5: begin
        in_pre_c = ocs_pkg::IN_DIV_4;
        vco_c    = ocs_pkg::VCO_MUL_40;
        div_c    = ocs_pkg::PLL_DIV_2;
        fac_c    = ocs_pkg::FACTOR_5; // see R14
      end
      ocs_pkg::MODE_X10: begin
        in_pre_c = ocs_pkg::IN_DIV_2;
        vco_c    = ocs_pkg::VCO_MUL_40;
        div_c    = ocs_pkg::PLL_DIV_2;
        fac_c    = ocs_pkg::FACTOR_10; // see R15
      end
      ocs_pkg::MODE_X16: begin
        in_pre_c = ocs_pkg::IN_DIV_2;
        vco_c    = ocs_pkg::VCO_MUL_64;
        div_c    = ocs_pkg::PLL_DIV_2;
        fac_c    = ocs_pkg::FACTOR_16; // see R15
      end
      default: begin
        in_pre_c = ocs_pkg::IN_DIV_1; // see R16
        vco_c    = ocs_pkg::VCO_MUL_0;
        div_c    = ocs_pkg::PLL_DIV_1;
        fac_c    = ocs_pkg::FACTOR_1;
      end
    endcase
  end

  // ----------------------------------------
  // Watchdog enable, counter and source switch.
  // ----------------------------------------
  logic       owd_en_q;
  logic       owd_en_d;
  logic [4:0] wd_cnt_q;
  logic [4:0] wd_cnt_d;
  logic       irq_q;
  logic       irq_d;
  logic [4:0] rs_cnt_q;
  logic [4:0] rs_cnt_d;
  logic       rs_q;
  logic       rs_d;
  ocs_pkg::ocs_src_e src_q;
  ocs_pkg::ocs_src_e src_d;
  logic       overflow;
  logic       wd_active;

  localparam logic [4:0] OVF_LAST = 5'(ocs_pkg::OWD_OVF_CYCLES - 1);

  assign wd_active = direct_mode & owd_en_q & (src_q == ocs_pkg::OCS_EXT);
  assign overflow  = wd_active & pll_rise & ~xtal_chg & (wd_cnt_q == OVF_LAST); // see R7

  always_comb begin
    owd_en_d = owd_en_q;
    if (cfg_write && system_config_register[ocs_pkg::SYSTEM_CONFIG_REGISTER_OSC_WATCHDOG_DISABLE_BIT]) begin
      owd_en_d = 1'b0; // see R4
    end
    wd_cnt_d = wd_cnt_q;
    if (!wd_active || xtal_chg) begin
      wd_cnt_d = '0; // see R6
    end else if (pll_rise && wd_cnt_q != OVF_LAST) begin
      wd_cnt_d = wd_cnt_q + 5'h01; // see R5
    end
    irq_d = irq_q | overflow; // see R8
    src_d = src_q;
    case (src_q)
      ocs_pkg::OCS_EXT:  if (overflow) src_d = ocs_pkg::OCS_SWAP;
      ocs_pkg::OCS_SWAP: if (pll_chg && !pll_s) src_d = ocs_pkg::OCS_BACK; // see R18
      ocs_pkg::OCS_BACK: src_d = ocs_pkg::OCS_BACK; // see R9
      default:           src_d = ocs_pkg::OCS_EXT;
    endcase
    rs_cnt_d = rs_cnt_q;
    rs_d     = 1'b0;
    if (!direct_mode && xtal_chg) begin
      if (rs_cnt_q + 5'h01 >= fac_c) begin
        rs_cnt_d = '0;
        rs_d     = 1'b1; // see R13
      end else begin
        rs_cnt_d = rs_cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      owd_en_q <= 1'b1; // see R3
      wd_cnt_q <= '0;
      irq_q    <= 1'b0;
      src_q    <= ocs_pkg::OCS_EXT; // see R10
      rs_cnt_q <= '0;
      rs_q     <= 1'b0;
    end else begin
      owd_en_q <= owd_en_d;
      wd_cnt_q <= wd_cnt_d;
      irq_q    <= irq_d;
      src_q    <= src_d;
      rs_cnt_q <= rs_cnt_d;
      rs_q     <= rs_d;
    end
  end

  // ----------------------------------------
  // Registered outputs.
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clock_mode        <= 3'h0;
      pll_enable        <= 1'b0;
      pll_free_run      <= 1'b0;
      in_prescale       <= ocs_pkg::IN_DIV_1;
      vco_multiply      <= ocs_pkg::VCO_MUL_0;
      pll_divide        <= ocs_pkg::PLL_DIV_1;
      out_prescale_half <= 1'b0;
      clock_factor      <= ocs_pkg::FACTOR_1;
      resync_pulse      <= 1'b0;
      owd_enabled       <= 1'b0;
      owd_irq_flag      <= 1'b0;
      sel_ext_clk       <= 1'b1;
      sel_backup_clk    <= 1'b0;
    end else begin
      clock_mode        <= mode_q;
      pll_enable        <= ~direct_mode | owd_en_q; // see R11 see R12
      pll_free_run      <= direct_mode & owd_en_q; // see R5
      in_prescale       <= in_pre_c;
      vco_multiply      <= vco_c;
      pll_divide        <= div_c;
      out_prescale_half <= (mode_q == ocs_pkg::MODE_PRESCALE) & (src_q == ocs_pkg::OCS_EXT); // see R16
      clock_factor      <= fac_c;
      resync_pulse      <= rs_q;
      owd_enabled       <= direct_mode & owd_en_q; // see R2
      owd_irq_flag      <= irq_q;
      sel_ext_clk       <= (src_q == ocs_pkg::OCS_EXT); // see R18
      sel_backup_clk    <= (src_q == ocs_pkg::OCS_BACK); // see R8
    end
  end

endmodule

// ### core/ocs_pkg.sv
// Constants for the oscillator watchdog and clock mode selection block.
package ocs_pkg;

  // ----------------------------------------
  // Mode codes taken from the three mode pins.
  // ----------------------------------------
  localparam logic [2:0] MODE_X4       = 3'h7;
  localparam logic [2:0] MODE_X3       = 3'h6;
  localparam logic [2:0] MODE_X8       = 3'h5;
  localparam logic [2:0] MODE_X5       = 3'h4;
  localparam logic [2:0] MODE_DIRECT   = 3'h3;
  localparam logic [2:0] MODE_X10      = 3'h2;
  localparam logic [2:0] MODE_PRESCALE = 3'h1;
  localparam logic [2:0] MODE_X16      = 3'h0;

  // ----------------------------------------
  // PLL settings per mode.
  // ----------------------------------------
  localparam logic [2:0] IN_DIV_4   = 3'h4;
  localparam logic [2:0] IN_DIV_2   = 3'h2;
  localparam logic [2:0] IN_DIV_1   = 3'h1;
  localparam logic [6:0] VCO_MUL_64 = 7'h40;
  localparam logic [6:0] VCO_MUL_48 = 7'h30;
  localparam logic [6:0] VCO_MUL_40 = 7'h28;
  localparam logic [6:0] VCO_MUL_0  = 7'h00;
  localparam logic [2:0] PLL_DIV_4  = 3'h4;
  localparam logic [2:0] PLL_DIV_2  = 3'h2;
  localparam logic [2:0] PLL_DIV_1  = 3'h1;
  localparam logic [4:0] FACTOR_16  = 5'h10;
  localparam logic [4:0] FACTOR_10  = 5'h0a;
  localparam logic [4:0] FACTOR_8   = 5'h08;
  localparam logic [4:0] FACTOR_5   = 5'h05;
  localparam logic [4:0] FACTOR_4   = 5'h04;
  localparam logic [4:0] FACTOR_3   = 5'h03;
  localparam logic [4:0] FACTOR_1   = 5'h01;

  // ----------------------------------------
  // Watchdog and configuration constants.
  // ----------------------------------------
  localparam int         OWD_OVF_CYCLES   = 16;
  localparam int         SYSTEM_CONFIG_REGISTER_OSC_WATCHDOG_DISABLE_BIT = 4;

  typedef enum logic [2:0] {
    OCS_EXT   = 3'b001,
    OCS_SWAP  = 3'b010,
    OCS_BACK  = 3'b100
  } ocs_src_e;

endpackage

// ### core/ocs_sync.sv
// Two-stage synchroniser with a change detector on the second stage.
`timescale 1ns/10ps
module ocs_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout,
  output logic      changed
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic s1_d;
  logic s2_d;
  logic s3_d;

  always_comb begin
    s1_d = din;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign dout    = s2_q;
  assign changed = s2_q ^ s3_q;
endmodule

// ### verification/ocs_xtal_model.sv
// Behavioural external clock source that can fail and recover.
`timescale 1ns/10ps
module ocs_xtal_model (
  input  wire logic       clk_sys,
  input  wire logic       run,
  input  wire logic [7:0] half,
  output logic            xtal
);
  int cnt = 0;
  initial xtal = 1'b0;
  // A failed source stops toggling and holds its level.
  always @(negedge clk_sys) begin
    if (run) begin
      cnt = cnt + 1;
      if (cnt >= half) begin
        xtal = ~xtal;
        cnt = 0;
      end
    end
  end
endmodule

// ### verification/ocs_clock_select_checker.sv
// Assertion checker for the clock select block.
`timescale 1ns/10ps
module ocs_clock_select_checker (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [2:0] clock_mode,
  input wire logic       cfg_write,
  input wire logic [7:0] system_config_register,
  input wire logic       pll_enable,
  input wire logic       pll_free_run,
  input wire logic [4:0] clock_factor,
  input wire logic       resync_pulse,
  input wire logic       owd_enabled,
  input wire logic       owd_irq_flag,
  input wire logic       sel_ext_clk,
  input wire logic       sel_backup_clk
);
  logic [1:0] up_q;
  logic       up;
  logic       dir;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      up_q <= 2'h0;
    end else if (!up) begin
      up_q <= up_q + 2'h1;
    end
  end
  assign up = (up_q == 2'h3);
  assign dir = !clock_mode[2] && clock_mode[0];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_swap;
    $fell(sel_ext_clk);
  endsequence
  sequence s_backup;
    ##[1:20] sel_backup_clk;
  endsequence
  a_irq_sticky: assert property (owd_irq_flag |=> owd_irq_flag)
    else $error("irq flag dropped");
  a_ext_no_return: assert property (!sel_ext_clk |=> !sel_ext_clk)
    else $error("external clock came back");
  a_no_overlap: assert property (!(sel_ext_clk && sel_backup_clk))
    else $error("both sources selected");
  a_backup_soon: assert property (s_swap |-> s_backup)
    else $error("backup clock late");
  a_disable_lat: assert property (cfg_write && system_config_register[4] |-> ##2 !owd_enabled)
    else $error("watchdog not disabled");
  a_owd_direct: assert property (owd_enabled |-> dir && pll_free_run)
    else $error("watchdog outside direct modes");
  a_pll_modes: assert property (up && !dir |-> pll_enable && !owd_enabled && clock_factor != 5'h01)
    else $error("pll mode wrong");
  a_resync_gap: assert property (resync_pulse |-> pll_enable ##1 !resync_pulse)
    else $error("resync pulse wrong");
endmodule

bind ocs_clock_select ocs_clock_select_checker u_chk (.*);

// ### verification/tb_osc_watchdog_pll_clock_select.sv
// Self-checking testbench for the clock select block.
`timescale 1ns/10ps
module tb_osc_watchdog_pll_clock_select;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] clock_mode_pins = 3'h3;
  logic       pll_free_clk = 1'b0;
  logic       cfg_write = 1'b0;
  logic [7:0] system_config_register = 8'h00;
  logic       run = 1'b1;
  logic [7:0] half = 8'h03;
  logic       crystal_input_pin;
  logic [2:0] clock_mode, in_prescale, pll_divide;
  logic [6:0] vco_multiply;
  logic [4:0] clock_factor;
  logic       pll_enable, pll_free_run, out_prescale_half, resync_pulse;
  logic       owd_enabled, owd_irq_flag, sel_ext_clk, sel_backup_clk;
  int         num_errors = 0;
  int         n_checks = 0;

  ocs_clock_select uut (
    .clk_sys                (clk_sys),
    .rst                    (rst),
    .clock_mode_pins        (clock_mode_pins),
    .crystal_input_pin      (crystal_input_pin),
    .pll_free_clk           (pll_free_clk),
    .cfg_write              (cfg_write),
    .system_config_register (system_config_register),
    .clock_mode             (clock_mode),
    .pll_enable             (pll_enable),
    .pll_free_run           (pll_free_run),
    .in_prescale            (in_prescale),
    .vco_multiply           (vco_multiply),
    .pll_divide             (pll_divide),
    .out_prescale_half      (out_prescale_half),
    .clock_factor           (clock_factor),
    .resync_pulse           (resync_pulse),
    .owd_enabled            (owd_enabled),
    .owd_irq_flag           (owd_irq_flag),
    .sel_ext_clk            (sel_ext_clk),
    .sel_backup_clk         (sel_backup_clk)
  );
  ocs_xtal_model model (.clk_sys(clk_sys), .run(run), .half(half), .xtal(crystal_input_pin));

  initial forever #5 clk_sys = ~clk_sys;
  initial forever begin
    repeat (3) @(negedge clk_sys);
    pll_free_clk = ~pll_free_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Pins change after reset to show that only the reset value counts.
  task automatic do_reset(input logic [2:0] m);
    clock_mode_pins = m;
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    clock_mode_pins = ~m;
    cyc(3);
  endtask

  task automatic cfg(input logic [7:0] d);
    system_config_register = d;
    cfg_write = 1'b1;
    cyc(1);
    cfg_write = 1'b0;
    cyc(3);
  endtask

  function automatic logic [17:0] pll_set(input logic [2:0] m);
    case (m)
      3'h7: return {3'h4, 7'h40, 3'h4, 5'h04};
      3'h6: return {3'h4, 7'h30, 3'h4, 5'h03};
      3'h5: return {3'h4, 7'h40, 3'h2, 5'h08};
      3'h4: return {3'h4, 7'h28, 3'h2, 5'h05};
      3'h2: return {3'h2, 7'h28, 3'h2, 5'h0a};
      3'h0: return {3'h2, 7'h40, 3'h2, 5'h10};
      default: return {3'h1, 7'h00, 3'h1, 5'h01};
    endcase
  endfunction

  // Every mode code, its settings and its resync rate over 32 transitions.
  task automatic t_modes();
    int   e;
    int   rs;
    logic dir;
    for (int m = 7; m >= 0; m--) begin
      do_reset(3'(m));
      dir = (m == 3) || (m == 1);
      check("mode", {clock_mode, pll_enable, owd_enabled, pll_free_run, out_prescale_half},
            {3'(m), 1'b1, dir, dir, m == 1});
      check("pll", {in_prescale, vco_multiply, pll_divide, clock_factor}, pll_set(3'(m)));
      e = dir ? 0 : 32 / int'(pll_set(3'(m)) & 18'h1f);
      rs = 0;
      repeat (96) begin
        @(negedge clk_sys);
        rs += int'(resync_pulse === 1'b1);
      end
      check("resync", dir ? rs : ((rs + 1 >= e) && (rs <= e + 1)), dir ? 0 : 1);
    end
  endtask

  // Crystal stops; the watchdog swaps to backup only where it is active.
  task automatic t_fail(input logic [2:0] m, input logic dis, input logic bad);
    do_reset(m);
    check("fresh", {sel_ext_clk, sel_backup_clk, owd_irq_flag}, 3'h4);
    if (dis) begin
      cfg(8'hef);
      check("keep", owd_enabled, 1'b1);
      cfg(8'h10);
      check("off", {owd_enabled, pll_enable}, 2'h0);
      cfg(8'h00);
      check("stay off", owd_enabled, 1'b0);
    end
    run = 1'b0;
    cyc(84);
    check("early", owd_irq_flag, 1'b0);
    cyc(24);
    check("swap", {owd_irq_flag, sel_ext_clk}, {bad, !bad});
    run = 1'b1;
    cyc(60);
    check("hold", {sel_ext_clk, sel_backup_clk}, {!bad, bad});
    check("half", out_prescale_half, (m == 3'h1) && !bad);
  endtask

  // Slow but live crystal keeps clearing the counter.
  task automatic t_slow();
    do_reset(3'h3);
    half = 8'h28;
    cyc(400);
    check("slow", {owd_irq_flag, sel_ext_clk}, 2'h1);
    half = 8'h03;
  endtask

  initial begin
    t_fail(3'h3, 1'b0, 1'b1);
    t_fail(3'h1, 1'b0, 1'b1);
    t_fail(3'h1, 1'b1, 1'b0);
    t_fail(3'h7, 1'b0, 1'b0);
    t_slow();
    t_modes();
    stop_test();
  end

  initial begin
    #200us;
    num_errors++;
    stop_test();
  end
endmodule
